// ===== design/dds_mode_and_clock_control.sv
// programming port, clock control, mode decode and oscillator core of the synthesizer
// Functional notes
// - select pin low serial, high parallel
// - init reset clears bus, loads default registers
// - differential enable picks paired reference inputs
// - bypass bit sends reference straight to core
// - multiplier factor four to twenty otherwise
// - three-bit mode field in register 0x1F
// - mode codes: tone, FSK, ramped, chirp, BPSK
// - 48-bit phase accumulator steps by tuning word
// - two 14-bit phase offsets, keying picks one
// - 12-bit multiplier scales cosine samples (code scales triangle samples)
// - new tuning word taken every clock
// - after init: single-tone, first word zero
// - modes enable only their own functions
// - keying low first, high second word/phase
// - chirp: keying high holds sweep, low runs
`timescale 1ns/1ns
module dds_mode_and_clock_control
   import dds_ctrl_pkg::*;
   (input wire logic i_ref_clk, // system clock, 50 MHz
    input wire logic i_rst_b, // async reset, active low
    input wire logic i_master_reset, // init reset pin, active high
    input wire logic i_sp_select, // 0 serial, 1 parallel
    input wire logic i_diff_reference_clock_in_enable, // differential reference enable
    input wire logic i_keying_select_input, // Keying_select_input keying pin
    input wire logic i_wr_n, // parallel write strobe / serial clock
    input wire logic i_rd_n, // parallel read strobe / serial select
    input wire logic [5:0] i_addr, // parallel address, bit 0 serial data in
    input wire logic [7:0] i_data, // parallel data bus in
    output logic [7:0] o_data, // parallel data bus out
    output logic o_data_oe, // parallel bus drive enable
    output logic o_sdo, // serial data out
    output logic o_diff_reference_clock_in_sel, // reference taken as differential pair
    output logic o_pll_bypass, // multiplier bypassed
    output logic [4:0] o_pll_mult, // multiplier factor in use
    output op_mode_t o_mode, // decoded operating mode
    output logic o_mode_valid, // mode field holds a defined code
    output logic [13:0] o_phase, // phase word with offset
    output logic [11:0] o_sample); // triangle sample, scaled when amplitude enabled
   typedef struct packed {
      logic [NREG-1:0][7:0] regs;
      logic [47:0] phase_acc;
      logic [47:0] freq_acc;
      logic [19:0] ramp_cnt;
      logic prev_key;
      logic prev_wr_n;
      logic prev_sclk;
      ser_state_t ser_state;
      logic [2:0] ser_cnt;
      logic [7:0] ser_shift;
      logic [5:0] ser_addr;
      logic ser_read;
      logic [7:0] data;
      logic data_oe;
      logic sdo;
      logic diff_sel;
      logic bypass;
      logic [4:0] mult;
      op_mode_t mode;
      logic mode_valid;
      logic [13:0] phase;
      logic [11:0] sample;
   } state_t;

   state_t q_r;
   state_t q_nxt;
   pin_bus_t raw_pins;
   pin_bus_t pins;
   logic [47:0] ftw_c;

   // pack a big-endian byte run into a word
   function automatic logic [47:0] word48(input logic [NREG-1:0][7:0] m,
                                          input logic [5:0] ofs, input int nb);
      logic [47:0] w;
      w = '0;
      for (int i = 0; i < nb; i++)
      begin
         w = {w[39:0], m[ofs + 6'(i)]};
      end
      return w;
   endfunction : word48

   // constant reset picture of all state
   function automatic state_t rst_state();
      state_t s;
      s = '0;
      s.regs[CLKMUL_OFS] = CLKMUL_RST;
      s.regs[MODE_OFS] = MODE_RST;
      s.prev_wr_n = 1'b1;
      s.prev_sclk = 1'b1; // serial clock idles high, no false edge after reset
      s.bypass = CLKMUL_RST[BYPASS_BIT];
      s.mult = MULT_MIN;
      s.mode = MODE_SINGLE;
      s.mode_valid = 1'b1;
      return s;
   endfunction : rst_state

   assign raw_pins = '{master_reset: i_master_reset, sp_select: i_sp_select,
                       diff_reference_clock_in_enable: i_diff_reference_clock_in_enable,
                       keying_select_input: i_keying_select_input, wr_n: i_wr_n,
                       rd_n: i_rd_n, sclk: i_wr_n, cs_n: i_rd_n, sdio: i_addr[0],
                       addr: i_addr, data: i_data};

   pin_sync #(.W($bits(pin_bus_t)), .RST_VAL(PIN_RST)) u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_pins(raw_pins),
      .o_pins(pins)
   );

   // next-state logic for ports, clock control and oscillator core
   always_comb
   begin
      logic [47:0] f1;
      logic [47:0] f2;
      logic [47:0] dfw;
      logic [47:0] top;
      logic [13:0] pofs;
      logic [11:0] tri_s;
      logic [23:0] prod;
      logic [4:0] mf;
      logic key;
      logic tick;
      logic kchg;
      op_mode_t md;
      f1 = word48(q_r.regs, FTW1_OFS, 6);
      f2 = word48(q_r.regs, FTW2_OFS, 6);
      dfw = word48(q_r.regs, DFW_OFS, 6);
      top = f2 - f1;
      key = pins.keying_select_input;
      kchg = key != q_r.prev_key;
      md = op_mode_t'(q_r.regs[MODE_OFS][MODE_LSB +: 3]);
      pofs = 14'(word48(q_r.regs, PHASE1_OFS, 2));
      tick = q_r.ramp_cnt == 20'h0_0000;
      mf = q_r.regs[CLKMUL_OFS][MULT_LSB +: 5];
      // triangle stands in for the cosine table to save area
      tri_s = q_r.phase[13] ? q_r.phase[12:1] : ~q_r.phase[12:1];
      prod = tri_s * 12'(word48(q_r.regs, AMPL_OFS, 2));
      q_nxt = q_r;
      q_nxt.prev_key = key;
      q_nxt.prev_wr_n = pins.wr_n;
      q_nxt.prev_sclk = pins.sclk;
      ftw_c = f1;

      // mode gating: each mode uses only the word, offset and sweep it owns
      case (md)
         MODE_FSK:
         begin
            ftw_c = key ? f2 : f1;
            q_nxt.freq_acc = '0;
         end
         MODE_RFSK:
         begin
            // sweep steps at the ramp rate and stops at the far word
            ftw_c = f1 + q_r.freq_acc;
            q_nxt.ramp_cnt = (tick || kchg) ? 20'(word48(q_r.regs, RAMP_OFS, 3))
                                            : q_r.ramp_cnt - 20'h0_0001;
            if (tick && key && (top - q_r.freq_acc) >= dfw)
            begin
               q_nxt.freq_acc = q_r.freq_acc + dfw;
            end
            else if (tick && !key && q_r.freq_acc >= dfw)
            begin
               q_nxt.freq_acc = q_r.freq_acc - dfw;
            end
         end
         MODE_CHIRP:
         begin
            ftw_c = f1 + q_r.freq_acc;
            if (!key)
            begin
               q_nxt.ramp_cnt = tick ? 20'(word48(q_r.regs, RAMP_OFS, 3))
                                     : q_r.ramp_cnt - 20'h0_0001;
               if (tick)
               begin
                  q_nxt.freq_acc = q_r.freq_acc + dfw;
               end
            end
         end
         MODE_BPSK:
         begin
            // second offset is reachable only here
            pofs = key ? 14'(word48(q_r.regs, PHASE2_OFS, 2))
                       : 14'(word48(q_r.regs, PHASE1_OFS, 2));
            q_nxt.freq_acc = '0;
         end
         default:
         begin
            // single-tone and undefined codes: first word, no sweep
            q_nxt.freq_acc = '0;
         end
      endcase

      // new tuning word enters the accumulator every clock, phase-continuous
      q_nxt.phase_acc = q_r.phase_acc + ftw_c;
      q_nxt.phase = q_r.phase_acc[47:34] + pofs;
      // amplitude word scales the sample only when enabled
      q_nxt.sample = q_r.regs[MODE_OFS][AMP_EN_BIT] ? prod[23:12] : tri_s;

      // clock source control; out-of-range factors clamp to the legal span
      q_nxt.diff_sel = pins.diff_reference_clock_in_enable;
      q_nxt.bypass = q_r.regs[CLKMUL_OFS][BYPASS_BIT];
      q_nxt.mult = (mf < MULT_MIN) ? MULT_MIN : ((mf > MULT_MAX) ? MULT_MAX : mf);
      q_nxt.mode = md;
      q_nxt.mode_valid = md <= MODE_BPSK;

      // programming port: parallel strobes or serial clock, chosen by select pin
      q_nxt.data_oe = 1'b0;
      if (pins.sp_select)
      begin
         q_nxt.ser_state = SER_INSTR;
         q_nxt.ser_cnt = '0;
         q_nxt.data = q_r.regs[pins.addr];
         q_nxt.data_oe = !pins.rd_n;
         if (pins.wr_n && !q_r.prev_wr_n)
         begin
            q_nxt.regs[pins.addr] = pins.data;
         end
      end
      else if (pins.cs_n)
      begin
         // deselect aborts a half-shifted byte
         q_nxt.ser_state = SER_INSTR;
         q_nxt.ser_cnt = '0;
      end
      else if (pins.sclk && !q_r.prev_sclk)
      begin
         q_nxt.ser_shift = {q_r.ser_shift[6:0], pins.sdio};
         q_nxt.ser_cnt = q_r.ser_cnt + 3'h1;
         q_nxt.sdo = q_r.ser_shift[7];
         if (q_r.ser_cnt == 3'h7)
         begin
            case (q_r.ser_state)
               SER_INSTR:
               begin
                  q_nxt.ser_read = q_r.ser_shift[SER_RD_BIT - 1];
                  q_nxt.ser_addr = {q_r.ser_shift[4:0], pins.sdio};
                  q_nxt.ser_shift = q_r.regs[{q_r.ser_shift[4:0], pins.sdio}];
                  q_nxt.ser_state = SER_DATA;
               end
               SER_DATA:
               begin
                  if (!q_r.ser_read)
                  begin
                     q_nxt.regs[q_r.ser_addr] = {q_r.ser_shift[6:0], pins.sdio};
                  end
                  q_nxt.ser_state = SER_INSTR;
               end
               default:
               begin
                  q_nxt.ser_state = SER_INSTR;
               end
            endcase
         end
      end

      // init reset reloads every register and drops any bus transfer
      if (pins.master_reset)
      begin
         q_nxt = rst_state();
         q_nxt.prev_key = key;
         q_nxt.prev_wr_n = pins.wr_n;
         q_nxt.prev_sclk = pins.sclk;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         q_r <= rst_state();
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign o_data = q_r.data;
   assign o_data_oe = q_r.data_oe;
   assign o_sdo = q_r.sdo;
   assign o_diff_reference_clock_in_sel = q_r.diff_sel;
   assign o_pll_bypass = q_r.bypass;
   assign o_pll_mult = q_r.mult;
   assign o_mode = q_r.mode;
   assign o_mode_valid = q_r.mode_valid;
   assign o_phase = q_r.phase;
   assign o_sample = q_r.sample;

   // checks on the control behaviour
   mode_decode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !$past(pins.master_reset)
      |-> o_mode_valid == ($past(q_r.regs[MODE_OFS][2:0]) <= 3'h4))
      else $error("mode valid flagged for undefined code");
   bypass_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !$past(pins.master_reset)
      |-> o_pll_bypass == $past(q_r.regs[CLKMUL_OFS][BYPASS_BIT]))
      else $error("bypass output does not follow register bit");
   mult_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_pll_mult >= 5'h04 && o_pll_mult <= 5'h14)
      else $error("multiplier factor out of range");
   phase_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !$past(pins.master_reset) |-> q_r.phase_acc == $past(q_r.phase_acc) + $past(ftw_c))
      else $error("phase accumulator did not step by tuning word");
   chirp_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (q_r.mode == MODE_CHIRP && q_r.regs[MODE_OFS][2:0] == 3'h3
       && pins.keying_select_input && !pins.master_reset) |=> $stable(q_r.freq_acc))
      else $error("chirp sweep moved while held");
   sweep_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (q_r.regs[MODE_OFS][2:0] inside {3'h0, 3'h1, 3'h4}) |=> q_r.freq_acc == '0)
      else $error("sweep active in a mode without sweep");
   init_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      pins.master_reset |=> q_r.regs[MODE_OFS] == 8'h00 && q_r.regs[FTW1_OFS] == 8'h00
      ##1 o_mode == MODE_SINGLE)
      else $error("init reset did not restore defaults");
   serial_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !pins.sp_select |=> !o_data_oe)
      else $error("parallel bus driven in serial mode");
   fsk_select_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (q_r.regs[MODE_OFS][2:0] == 3'h1 && pins.keying_select_input)
      |-> ftw_c == word48(q_r.regs, FTW2_OFS, 6))
      else $error("FSK keying high did not pick second word");
endmodule : dds_mode_and_clock_control

// ===== design/dds_ctrl_pkg.sv
// shared constants, register map and carrier types of the synthesizer control block
package dds_ctrl_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int NREG = 64;
   // register byte offsets, multi-byte words stored most significant byte first
   localparam logic [5:0] PHASE1_OFS = 6'h00;
   localparam logic [5:0] PHASE2_OFS = 6'h02;
   localparam logic [5:0] FTW1_OFS = 6'h04;
   localparam logic [5:0] FTW2_OFS = 6'h0A;
   localparam logic [5:0] DFW_OFS = 6'h10;
   localparam logic [5:0] RAMP_OFS = 6'h1A;
   localparam logic [5:0] CLKMUL_OFS = 6'h1E;
   localparam logic [5:0] MODE_OFS = 6'h1F;
   localparam logic [5:0] AMPL_OFS = 6'h21;
   // field positions
   localparam int BYPASS_BIT = 5;
   localparam int MULT_LSB = 0;
   localparam int MODE_LSB = 0;
   localparam int AMP_EN_BIT = 5;
   localparam int SER_RD_BIT = 7;
   // reset values: multiplier bypassed at factor four, single-tone, all else zero
   localparam logic [7:0] CLKMUL_RST = 8'h24;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [4:0] MULT_MIN = 5'h04;
   localparam logic [4:0] MULT_MAX = 5'h14;
   // operating modes as encoded in the mode field
   typedef enum logic [2:0] {
      MODE_SINGLE = 3'h0,
      MODE_FSK = 3'h1,
      MODE_RFSK = 3'h2,
      MODE_CHIRP = 3'h3,
      MODE_BPSK = 3'h4
   } op_mode_t;
   // serial port states, gray along instruction then data
   typedef enum logic [1:0] {
      SER_INSTR = 2'b00,
      SER_DATA = 2'b01
   } ser_state_t;
   // pins that arrive from outside the clock domain
   typedef struct packed {
      logic master_reset;
      logic sp_select;
      logic diff_reference_clock_in_enable;
      logic keying_select_input;
      logic wr_n;
      logic rd_n;
      logic sclk;
      logic cs_n;
      logic sdio;
      logic [5:0] addr;
      logic [7:0] data;
   } pin_bus_t;
   // idle levels of the pins so that no strobe edge appears after reset
   localparam pin_bus_t PIN_RST = '{wr_n: 1'b1, rd_n: 1'b1, sclk: 1'b1, cs_n: 1'b1,
                                    default: '0};
endpackage : dds_ctrl_pkg

// ===== design/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync
   #(parameter int W = 1,
     parameter logic [W-1:0] RST_VAL = '0)
   (input wire logic i_ref_clk, // system clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic [W-1:0] i_pins, // raw pin levels
    output logic [W-1:0] o_pins); // filtered levels
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } sync_t;
   sync_t q_r;
   sync_t q_nxt;

   if (W < 1)
   begin : g_chk
      $error("pin_sync width must be positive");
   end

   // a bit moves only when stages two and three agree; stage one feeds stage two alone
   always_comb
   begin
      q_nxt = q_r;
      q_nxt.s1 = i_pins;
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      q_nxt.o = (~(q_r.s2 ^ q_r.s3) & q_r.s3) | ((q_r.s2 ^ q_r.s3) & q_r.o);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         q_r <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign o_pins = q_r.o;
endmodule : pin_sync

// ===== sim/dds_host_model.sv
// host controller model driving the programming pins of the synthesizer
`timescale 1ns/1ns
module dds_host_model
   (input wire logic i_ref_clk, // system clock
    input wire logic i_sdo, // serial read data
    input wire logic [7:0] i_data, // parallel read data
    input wire logic i_data_oe, // parallel bus driven by device
    output logic o_wr_n, // write strobe or serial clock
    output logic o_rd_n, // read strobe or serial select
    output logic [5:0] o_addr, // address, bit 0 serial data
    output logic [7:0] o_data, // write data
    output logic o_sp_select, // 0 serial, 1 parallel
    output logic o_master_reset); // init reset, active high
   // complementary reference pin is held at a fixed level on the board
   localparam logic REFERENCE_CLOCK_IN_N_TIE = 1'b0;
   // idle pin levels from time zero, strobes high
   initial
   begin
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_addr = 6'h00;
      o_data = 8'h00;
      o_sp_select = 1'b1;
      o_master_reset = 1'b0;
   end
   // all pin changes land just after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : cyc
   // init reset held long enough to pass the pin synchroniser
   task automatic init_pulse();
      o_master_reset = 1'b1;
      cyc(8);
      o_master_reset = 1'b0;
      cyc(8);
   endtask : init_pulse
   task automatic set_port(input logic p);
      o_sp_select = p;
      cyc(6);
   endtask : set_port
   // address and data held five cycles past the strobe rising edge
   task automatic par_wr(input logic [5:0] a, input logic [7:0] d);
      o_addr = a;
      o_data = d;
      cyc(1);
      o_wr_n = 1'b0;
      cyc(5);
      o_wr_n = 1'b1;
      cyc(5);
      o_data = ~d; // no stale value on a released bus
      cyc(2);
   endtask : par_wr
   task automatic par_rd(input logic [5:0] a, output logic [7:0] d, output logic oe);
      o_addr = a;
      o_rd_n = 1'b0;
      cyc(6);
      d = i_data;
      oe = i_data_oe;
      o_rd_n = 1'b1;
      cyc(6);
   endtask : par_rd
   // instruction then data byte, msb first, sdo taken late in each high phase of the data byte
   task automatic ser_xfer(input logic [15:0] w, output logic [7:0] q);
      o_rd_n = 1'b0;
      cyc(5);
      for (int i = 15; i >= 0; i--)
      begin
         o_wr_n = 1'b0;
         o_addr[0] = w[i];
         cyc(5);
         o_wr_n = 1'b1;
         cyc(6);
         if (i < 8)
            q[i] = i_sdo;
      end
      o_rd_n = 1'b1;
      o_addr[0] = ~o_addr[0];
      cyc(6);
   endtask : ser_xfer
endmodule : dds_host_model

// ===== sim/dds_mode_and_clock_control_tb.sv
// self-checking bench of the synthesizer control block
`timescale 1ns/1ns
module dds_mode_and_clock_control_tb;
   import dds_ctrl_pkg::*;
   logic clk, rst_b, diff, key, wr_n, rd_n, sp, mrst, oe, sdo, dsel, byp, mv;
   logic [5:0] addr;
   logic [7:0] wd, rdat, q;
   logic [4:0] mult, m;
   op_mode_t mode;
   logic [13:0] ph, s0, s1, p0;
   logic [11:0] smp;
   logic [7:0] cv [5] = '{8'h0A, 8'h03, 8'h1F, 8'h34, 8'h04};
   int errors, checked;
   dds_mode_and_clock_control dut_u (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_master_reset(mrst), .i_sp_select(sp), .i_diff_reference_clock_in_enable(diff),
      .i_keying_select_input(key), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_addr(addr),
      .i_data(wd), .o_data(rdat), .o_data_oe(oe), .o_sdo(sdo),
      .o_diff_reference_clock_in_sel(dsel), .o_pll_bypass(byp), .o_pll_mult(mult),
      .o_mode(mode), .o_mode_valid(mv), .o_phase(ph), .o_sample(smp));
   dds_host_model host_u (.i_ref_clk(clk), .i_sdo(sdo), .i_data(rdat), .i_data_oe(oe),
      .o_wr_n(wr_n), .o_rd_n(rd_n), .o_addr(addr), .o_data(wd), .o_sp_select(sp),
      .o_master_reset(mrst));
   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr_word(input logic [5:0] a, input logic [47:0] v, input int nb);
      for (int i = 0; i < nb; i++)
         host_u.par_wr(a + 6'(i), v[8*(nb-1-i) +: 8]);
   endtask : wr_word
   // parallel read also checks that the device drives the bus
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic e;
      host_u.par_rd(a, d, e);
      chk("read_oe", 16'h0001, 16'(e));
      chk("read_data", 16'(exp), 16'(d));
   endtask : rd
   // phase advance over one clock
   task automatic step(output logic [13:0] s);
      logic [13:0] p;
      cyc(1);
      p = ph;
      cyc(1);
      s = ph - p;
   endtask : step
   task automatic wrap_up();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      errors++;
      wrap_up();
   end
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      diff = 1'b0;
      key = 1'b0;
      errors = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      #1 rst_b = 1'b1;
      host_u.init_pulse();
      chk("bypass_rst", 16'h0001, 16'(byp));
      chk("mult_rst", 16'h0004, 16'(mult));
      chk("mode_rst", 16'(MODE_SINGLE), 16'(mode));
      rd(CLKMUL_OFS, CLKMUL_RST);
      rd(MODE_OFS, MODE_RST);
      rd(FTW1_OFS, 8'h00);
      step(s0);
      chk("idle_step", 16'h0000, 16'(s0));
      for (int c = 0; c < 8; c++)
      begin
         host_u.par_wr(MODE_OFS, 8'(c));
         chk("mode_valid", 16'(c < 5), 16'(mv));
         if (c < 5)
            chk("mode", 16'(c), 16'(mode));
      end
      for (int i = 0; i < 5; i++)
      begin
         m = cv[i][4:0];
         m = (m < MULT_MIN) ? MULT_MIN : (m > MULT_MAX) ? MULT_MAX : m;
         host_u.par_wr(CLKMUL_OFS, cv[i]);
         chk("bypass", 16'(cv[i][BYPASS_BIT]), 16'(byp));
         chk("mult", 16'(m), 16'(mult));
         rd(CLKMUL_OFS, cv[i]);
      end
      diff = 1'b1;
      cyc(6);
      chk("diff_sel", 16'h0001, 16'(dsel));
      diff = 1'b0;
      cyc(6);
      chk("diff_sel", 16'h0000, 16'(dsel));
      // step one lsb per clock on the first word, two on the second
      wr_word(FTW1_OFS, 48'h0004_0000_0000, 6);
      wr_word(FTW2_OFS, 48'h0008_0000_0000, 6);
      host_u.par_wr(MODE_OFS, 8'h00);
      step(s0);
      chk("tone_step", 16'h0001, 16'(s0));
      key = 1'b1;
      cyc(6);
      step(s0);
      chk("tone_key_step", 16'h0001, 16'(s0));
      host_u.par_wr(MODE_OFS, 8'h01);
      step(s0);
      chk("fsk_high_step", 16'h0002, 16'(s0));
      key = 1'b0;
      cyc(6);
      step(s0);
      chk("fsk_low_step", 16'h0001, 16'(s0));
      // stop the accumulator, then key between the two offsets
      wr_word(FTW1_OFS, 48'h0000_0000_0000, 6);
      wr_word(PHASE2_OFS, 48'h0000_0000_1000, 2);
      host_u.par_wr(MODE_OFS, 8'h04);
      cyc(6);
      p0 = ph;
      key = 1'b1;
      cyc(6);
      chk("bpsk_delta", 16'h1000, 16'(ph - p0));
      // chirp: keying high freezes the sweep
      wr_word(DFW_OFS, 48'h0004_0000_0000, 6);
      wr_word(RAMP_OFS, 48'h0000_0000_0001, 3);
      host_u.par_wr(MODE_OFS, 8'h03);
      step(s0);
      cyc(20);
      step(s1);
      chk("chirp_hold", 16'(s0), 16'(s1));
      key = 1'b0;
      cyc(16);
      key = 1'b1;
      cyc(6);
      step(s1);
      chk("chirp_moved", 16'h0001, 16'(s1 != s0));
      cyc(20);
      step(s0);
      chk("chirp_hold2", 16'(s1), 16'(s0));
      key = 1'b0;
      // serial port: write mode, read back the clock register
      host_u.set_port(1'b0);
      host_u.ser_xfer({2'b00, MODE_OFS, 8'h01}, q);
      chk("ser_mode", 16'(MODE_FSK), 16'(mode));
      host_u.ser_xfer({2'b10, CLKMUL_OFS, 8'h00}, q);
      chk("ser_read", 16'h0004, 16'(q));
      host_u.set_port(1'b1);
      // init reset in mid-run restores defaults
      host_u.par_wr(CLKMUL_OFS, 8'h0A);
      host_u.par_wr(MODE_OFS, 8'h02);
      host_u.init_pulse();
      chk("bypass_init", 16'h0001, 16'(byp));
      chk("mult_init", 16'h0004, 16'(mult));
      chk("mode_init", 16'(MODE_SINGLE), 16'(mode));
      rd(MODE_OFS, MODE_RST);
      rd(FTW2_OFS + 6'h01, 8'h00);
      // zero phase gives a full-scale sample; half amplitude halves it
      chk("sample_full", 16'h0FFF, 16'(smp));
      wr_word(AMPL_OFS, 48'h0000_0000_0800, 2);
      host_u.par_wr(MODE_OFS, 8'h20);
      chk("sample_half", 16'h07FF, 16'(smp));
      wrap_up();
   end
endmodule : dds_mode_and_clock_control_tb
